/* src/nand_ctrl_pkg.sv */
`default_nettype none
package nand_ctrl_pkg;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_RESET       = 8'hFF;
    localparam logic [7:0] CMD_READ_ADDR   = 8'h00;
    localparam logic [7:0] CMD_READ_START  = 8'h30;
    localparam logic [7:0] CMD_SERIAL_IN   = 8'h80;
    localparam logic [7:0] CMD_PROGRAM     = 8'h10;
    localparam logic [7:0] CMD_COL_CHANGE  = 8'h05;
    localparam logic [7:0] CMD_READ_COL    = 8'hE0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_START = 8'hD0;
    localparam logic [7:0] CMD_ID_READ     = 8'h90;
    // status byte bit positions (io_line_1 is bit 0)
    localparam int STAT_FAIL_BIT  = 0;
    localparam int STAT_READY_BIT = 5;
    localparam int STAT_WP_BIT    = 7;
    // fourth id byte fields
    localparam int ID4_PAGE_LSB  = 0;
    localparam int ID4_BLOCK_LSB = 4;
    localparam int ID4_SPARE_LSB = 2;
    localparam int ID4_ORG_BIT   = 6;
    // fifth id byte fields
    localparam int ID5_PLANES_LSB = 2;
    localparam int ID5_PSIZE_LSB  = 4;
    // strobe timing
    localparam int STROBE_NS     = 30;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage
`default_nettype wire

/* src/strobe_timer.sv */
`default_nettype none
module strobe_timer (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       start,
    output logic            done
);
    import nand_ctrl_pkg::*;
    logic [3:0] countReg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            countReg <= 4'h0;
            done     <= 1'b0;
        end else if (start) begin
            countReg <= STROBE_CNT;
            done     <= 1'b0;
        end else if (countReg == 4'h1) begin
            countReg <= 4'h0;
            done     <= 1'b1;
        end else begin
            done <= 1'b0;
            if (countReg != 4'h0) begin
                countReg <= countReg - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* src/nand_status_reset_cmd_gate.sv */
// Behaviour
// RULE1: the device runs program and erase with verify on its own, so the host only polls.
// RULE2: after a 70h command the host pulls the status byte with one read strobe.
// RULE3: bit io_line_1 of status is the pass/fail result, used only while ready.
// RULE4: bit io_line_6 of status is 1 when ready and 0 when busy.
// RULE5: bit io_line_8 of status is 0 when write protected and 1 when not.
// RULE6: with a shared ready/busy wire the host polls status to learn each device's state.
// RULE7: a reset command FFh aborts every device operation.
// RULE8: reset during program or erase discharges the high voltage and the device waits.
// RULE9: after power-up the device shows busy on ready_busy_out during initialization.
// RULE10: during power-up initialization the host issues only FFh or 70h.
// RULE11: the host holds write protect active around power-on and power-off.
// RULE12: the host never issues a command outside the defined set.
// RULE13: while busy the host issues only 70h or FFh.
// RULE14: ready_busy_out is open drain and wire-shared, needing a pull-up.
// RULE15: once in status mode the device stays there until a 00h command returns it; the code also leaves status mode on FFh.
// RULE16: fourth and fifth id bytes hold page, block, spare, width, plane count and plane size.
`default_nettype none
module nand_status_reset_cmd_gate (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cmdValid,
    input  wire logic [7:0] cmdCode,
    output logic            cmdReady,
    output logic            cmdRejected,
    input  wire logic       statusReq,
    output logic            statusValid,
    output logic [7:0]      statusByte,
    output logic            devReady,
    output logic            opFailed,
    output logic            devProtected,
    input  wire logic       powerGood,
    input  wire logic       writeEnable,
    input  wire logic [7:0] idByte4,
    input  wire logic [7:0] idByte5,
    output logic [1:0]      pageSizeCode,
    output logic [1:0]      blockSizeCode,
    output logic [1:0]      spareSizeCode,
    output logic            wideBus,
    output logic [1:0]      planeCountCode,
    output logic [2:0]      planeSizeCode,
    output logic            cmdLatchEn,
    output logic            addrLatchEn,
    output logic            chipEnable_n,
    output logic            writeStrobe_n,
    output logic            read_strobe_n,
    output logic            writeProtect_n,
    output logic [7:0]      ioOut,
    output logic            ioOe_n,
    input  wire logic [7:0] ioIn,
    input  wire logic       ready_busy_out
);
    import nand_ctrl_pkg::*;

    typedef enum logic [4:0] {
        IDLE    = 5'b00001,
        CMD_LO  = 5'b00010,
        CMD_HI  = 5'b00100,
        RD_LO   = 5'b01000,
        RD_HI   = 5'b10000
    } state_e;

    function automatic logic allowedWhileBusy(input logic [7:0] c);
        return (c == CMD_STATUS) || (c == CMD_RESET); // [RULE10] [RULE13]
    endfunction

    function automatic logic knownCmd(input logic [7:0] c);
        unique case (c)
            CMD_STATUS, CMD_RESET, CMD_READ_ADDR, CMD_READ_START, CMD_SERIAL_IN,
            CMD_PROGRAM, CMD_COL_CHANGE, CMD_READ_COL, CMD_ERASE_SETUP,
            CMD_ERASE_START, CMD_ID_READ: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    state_e     stateReg;
    logic [7:0] cmdLatchReg;
    logic       timerStart;
    logic       timerDone;
    logic       busySeen;
    logic       statusModeReg;

    strobe_timer u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (timerStart),
        .done    (timerDone)
    );

    // shared wire: low from any device reads busy [RULE14] [RULE6] [RULE9]
    assign busySeen = ~ready_busy_out;

    always_comb begin
        timerStart = 1'b0;
        unique case (stateReg)
            IDLE:   timerStart = (cmdValid && cmdReady) || (statusReq && cmdReady);
            CMD_LO: timerStart = timerDone;
            RD_LO:  timerStart = timerDone;
            CMD_HI, RD_HI: timerStart = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stateReg      <= IDLE;
            cmdLatchReg   <= 8'h00;
            cmdReady      <= 1'b0;
            cmdRejected   <= 1'b0;
            statusValid   <= 1'b0;
            cmdLatchEn    <= 1'b0;
            addrLatchEn   <= 1'b0;
            chipEnable_n  <= 1'b1;
            writeStrobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            ioOut         <= 8'h00;
            ioOe_n        <= 1'b1;
        end else begin
            cmdRejected <= 1'b0;
            statusValid <= 1'b0;
            unique case (stateReg)
                IDLE: begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady) begin
                        // unknown codes can corrupt data, busy allows only two [RULE12] [RULE13]
                        if (!knownCmd(cmdCode) || (busySeen && !allowedWhileBusy(cmdCode))) begin
                            cmdRejected <= 1'b1;
                        end else begin
                            cmdLatchReg   <= cmdCode;
                            cmdReady      <= 1'b0;
                            chipEnable_n  <= 1'b0;
                            cmdLatchEn    <= 1'b1;
                            writeStrobe_n <= 1'b0;
                            ioOut         <= cmdCode;
                            ioOe_n        <= 1'b0;
                            stateReg      <= CMD_LO;
                        end
                    end else if (statusReq && cmdReady) begin
                        // one read strobe fetches the status byte [RULE2]
                        cmdReady      <= 1'b0;
                        chipEnable_n  <= 1'b0;
                        read_strobe_n <= 1'b0;
                        stateReg      <= RD_LO;
                    end
                end
                CMD_LO: begin
                    if (timerDone) begin
                        writeStrobe_n <= 1'b1; // device latches on rising edge
                        stateReg      <= CMD_HI;
                    end
                end
                CMD_HI: begin
                    if (timerDone) begin
                        cmdLatchEn   <= 1'b0;
                        ioOe_n       <= 1'b1;
                        chipEnable_n <= 1'b1;
                        cmdReady     <= 1'b1;
                        stateReg     <= IDLE;
                    end
                end
                RD_LO: begin
                    if (timerDone) begin
                        read_strobe_n <= 1'b1;
                        statusValid   <= 1'b1;
                        stateReg      <= RD_HI;
                    end
                end
                RD_HI: begin
                    if (timerDone) begin
                        chipEnable_n <= 1'b1;
                        cmdReady     <= 1'b1;
                        stateReg     <= IDLE;
                    end
                end
            endcase
        end
    end

    // status byte captured while read strobe is low, before it rises
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            statusByte   <= STATUS_RESET;
            devReady     <= 1'b0;
            opFailed     <= 1'b0;
            devProtected <= 1'b1;
        end else if (stateReg == RD_LO && timerDone && statusModeReg) begin
            statusByte   <= ioIn;
            devReady     <= ioIn[STAT_READY_BIT]; // [RULE4] [RULE1]
            // fail bit only trusted when ready [RULE3]
            opFailed     <= ioIn[STAT_READY_BIT] & ioIn[STAT_FAIL_BIT];
            devProtected <= ~ioIn[STAT_WP_BIT]; // [RULE5]
        end
    end

    // status mode persists until 00h or FFh; FFh aborts all work [RULE15] [RULE7] [RULE8]
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            statusModeReg <= 1'b0;
        end else if (stateReg == CMD_HI && timerDone) begin
            if (cmdLatchReg == CMD_STATUS) begin
                statusModeReg <= 1'b1;
            end else if (cmdLatchReg == CMD_READ_ADDR || cmdLatchReg == CMD_RESET) begin
                statusModeReg <= 1'b0;
            end
        end
    end

    // write protect held active until supply good and user allows [RULE11]
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            writeProtect_n <= 1'b0;
        end else begin
            writeProtect_n <= powerGood & writeEnable;
        end
    end

    // decode of id bytes four and five [RULE16]
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pageSizeCode   <= 2'b00;
            blockSizeCode  <= 2'b00;
            spareSizeCode  <= 2'b00;
            wideBus        <= 1'b0;
            planeCountCode <= 2'b00;
            planeSizeCode  <= 3'b000;
        end else begin
            pageSizeCode   <= idByte4[ID4_PAGE_LSB +: 2];
            spareSizeCode  <= idByte4[ID4_SPARE_LSB +: 2];
            blockSizeCode  <= idByte4[ID4_BLOCK_LSB +: 2];
            wideBus        <= idByte4[ID4_ORG_BIT];
            planeCountCode <= idByte5[ID5_PLANES_LSB +: 2];
            planeSizeCode  <= idByte5[ID5_PSIZE_LSB +: 3];
        end
    end
endmodule
`default_nettype wire

/* sim/cmd_gate_sva.sv */
`default_nettype none
module cmd_gate_sva (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic       cmdReady,
    input wire logic       cmdRejected,
    input wire logic       statusReq,
    input wire logic       statusValid,
    input wire logic [7:0] statusByte,
    input wire logic       devReady,
    input wire logic       powerGood,
    input wire logic       writeEnable,
    input wire logic       cmdLatchEn,
    input wire logic       writeStrobe_n,
    input wire logic       read_strobe_n,
    input wire logic       writeProtect_n,
    input wire logic [7:0] ioOut,
    input wire logic       ioOe_n,
    input wire logic       ready_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import nand_ctrl_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    rej_pulse_a: assert property (cmdRejected |=> !cmdRejected)
        else $error("reject longer than one cycle");
    busy_gate_a: assert property (cmdValid && cmdReady && !ready_busy_out
        && cmdCode != CMD_STATUS && cmdCode != CMD_RESET |=> cmdRejected)
        else $error("command let through while busy");
    cmd_drive_a: assert property (cmdValid && cmdReady |=> cmdRejected
        || (cmdLatchEn && !ioOe_n && ioOut == $past(cmdCode)))
        else $error("accepted code not driven");
    stat_lat_a: assert property (statusReq && cmdReady && !cmdValid |-> ##5 statusValid)
        else $error("status not returned in time");
    stat_fields_a: assert property (statusValid |=> devReady == statusByte[STAT_READY_BIT])
        else $error("ready flag differs from status byte");
    we_width_a: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*4] ##1 writeStrobe_n)
        else $error("write strobe width wrong");
    no_contend_a: assert property (!read_strobe_n |-> ioOe_n && writeStrobe_n)
        else $error("bus driven during read strobe");
    wp_follow_a: assert property (!$past(reset) |->
        writeProtect_n == $past(powerGood && writeEnable))
        else $error("write protect not following power");
    ready_gap_a: assert property ((cmdReady && (cmdValid || statusReq)) ##1 !cmdRejected
        |-> !cmdReady [*8] ##1 cmdReady)
        else $error("ready gap wrong");
    cover property (cmdRejected);
    cover property (statusValid && !statusByte[STAT_READY_BIT]);
    cover property (cmdLatchEn && ioOut == CMD_RESET);
endmodule
bind nand_status_reset_cmd_gate cmd_gate_sva u_sva (.*);
`default_nettype wire

/* sim/nand_dev_model.sv */
`default_nettype none
module nand_dev_model #(
    parameter int INIT_CYC = 60,
    parameter int OP_CYC   = 40
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cmdLatchEn,
    input  wire logic       writeStrobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       writeProtect_n,
    input  wire logic [7:0] ioOut,
    input  wire logic       failIn,
    output logic [7:0]      ioIn,
    output logic            busyPull
);
    timeunit 1ns;
    timeprecision 1ps;
    import nand_ctrl_pkg::*;
    int   busyCnt;
    logic weLast, statMode, failReg, junk;
    always_ff @(posedge ref_clk) begin
        weLast <= writeStrobe_n;
        junk <= ~junk;
        if (reset) begin
            busyCnt <= INIT_CYC;
            statMode <= 1'b0;
            failReg <= 1'b0;
            junk <= 1'b0;
        end else if (cmdLatchEn && writeStrobe_n && !weLast) begin
            case (ioOut)
                CMD_STATUS: statMode <= 1'b1;
                CMD_READ_ADDR: statMode <= 1'b0;
                CMD_RESET: begin
                    busyCnt <= 2; // abort, discharge, wait
                    statMode <= 1'b0;
                end
                CMD_PROGRAM, CMD_ERASE_START: begin
                    busyCnt <= OP_CYC; // runs on its own
                    failReg <= failIn;
                end
                default: ;
            endcase
        end else if (busyCnt != 0) begin
            busyCnt <= busyCnt - 1;
        end
    end
    // released bus toggles so a stale byte never reads back
    assign ioIn = (!read_strobe_n && statMode) ?
        {writeProtect_n, 1'b0, busyCnt == 0, 4'h0, failReg} : {8{junk}};
    assign busyPull = busyCnt != 0; // open drain low
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_ctrl_pkg::*;
    logic ref_clk = 0, reset = 1, cmdValid = 0, statusReq = 0;
    logic powerGood = 0, writeEnable = 1, failIn = 0, rej, wideBus, busyPull, ready_busy_out;
    logic [7:0] cmdCode = 8'h00, idByte4 = 8'h00, idByte5 = 8'h00, ioIn, ioOut, statusByte, sv;
    logic cmdReady, cmdRejected, statusValid, devReady, opFailed, devProtected, cmdLatchEn;
    logic addrLatchEn, chipEnable_n, writeStrobe_n, read_strobe_n, writeProtect_n, ioOe_n;
    logic [1:0] pageSizeCode, blockSizeCode, spareSizeCode, planeCountCode;
    logic [2:0] planeSizeCode;
    logic [7:0] legal [7] = '{CMD_SERIAL_IN, CMD_READ_ADDR, CMD_READ_START, CMD_COL_CHANGE,
        CMD_READ_COL, CMD_ERASE_SETUP, CMD_ID_READ};
    int mismatches = 0, total_checks = 0, seed = 20;
    assign ready_busy_out = busyPull ? 1'b0 : 1'b1; // pull-up
    initial forever #5 ref_clk = ~ref_clk;
    nand_status_reset_cmd_gate u_dut (.*);
    nand_dev_model u_dev (.*);
    function automatic logic [7:0] expStat(logic f, logic r, logic w);
        return {w, 1'b0, r, 4'h0, f};
    endfunction
    task automatic check8(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // onLine picks the ready/busy wire, otherwise the user-side ready
    task automatic waitFor(input bit onLine, input int lim);
        int n = 0;
        while ((onLine ? ready_busy_out : cmdReady) !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        check8("wait bound", 1, onLine ? ready_busy_out : cmdReady);
    endtask
    task automatic sendCmd(logic [7:0] c);
        waitFor(0, 20);
        cmdValid = 1;
        cmdCode = c;
        @(negedge ref_clk);
        cmdValid = 0;
        rej = cmdRejected;
        @(negedge ref_clk);
        rej |= cmdRejected;
        waitFor(0, 20);
    endtask
    task automatic readStat;
        waitFor(0, 20);
        statusReq = 1;
        @(negedge ref_clk);
        statusReq = 0;
        @(negedge ref_clk);
        waitFor(0, 20);
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        reset = 0;
        sendCmd(CMD_SERIAL_IN);
        check8("init reject", 1, rej);
        sendCmd(CMD_STATUS);
        check8("init accept", 0, rej);
        readStat();
        check8("init status", expStat(0, 0, 0), statusByte);
        check8("protected", 1, devProtected);
        check8("idle pins", 8'h0E, {4'h0, chipEnable_n, writeStrobe_n, read_strobe_n, addrLatchEn});
        powerGood = 1;
        waitFor(1, 100);
        readStat();
        check8("ready status", expStat(0, 1, 1), statusByte);
        foreach (legal[i]) begin
            sendCmd(legal[i]);
            check8("legal code", 0, rej);
        end
        sendCmd(8'h55);
        check8("unknown code", 1, rej);
        $display("end of power-up and code tests");
        for (int i = 0; i < 6; i++) begin
            failIn = 1'($random(seed));
            writeEnable = 1'($random(seed));
            sendCmd(i[0] ? CMD_ERASE_SETUP : CMD_SERIAL_IN);
            sendCmd(i[0] ? CMD_ERASE_START : CMD_PROGRAM);
            sendCmd(legal[3'(unsigned'($random(seed)) % 7)]);
            check8("busy reject", 1, rej);
            sendCmd(CMD_STATUS);
            readStat();
            check8("busy bit", 0, statusByte[STAT_READY_BIT]);
            waitFor(1, 100);
            readStat();
            check8("op status", expStat(failIn, 1, writeEnable), statusByte);
            check8("fail flag", failIn, opFailed);
            check8("ready flag", 1, devReady);
        end
        $display("end of program and erase tests");
        writeEnable = 1;
        sendCmd(CMD_ERASE_SETUP);
        sendCmd(CMD_ERASE_START);
        sendCmd(CMD_RESET);
        check8("reset taken", 0, rej);
        check8("abort ready", 1, ready_busy_out);
        sendCmd(CMD_STATUS);
        readStat();
        sv = statusByte;
        sendCmd(CMD_READ_ADDR);
        readStat();
        check8("read mode", sv, statusByte);
        idByte4 = 8'($random(seed));
        idByte5 = 8'($random(seed));
        repeat (3) @(negedge ref_clk);
        check8("id4", idByte4 & 8'h7F, {1'b0, wideBus, blockSizeCode, spareSizeCode,
            pageSizeCode});
        check8("id5", idByte5 & 8'h7C, {1'b0, planeSizeCode, planeCountCode, 2'b00});
        $display("end of reset, mode and id tests");
        finish_test();
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
